// ---- common/gmr_pkg.sv ----
`default_nettype none
package gmr_pkg;
   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int NGRP = 4;
   localparam int NPIN = 11;
   localparam int STORE_BYTES = 768;
   localparam int STORE_WORDS = STORE_BYTES / 4;
   // ----------------------------------------------------------------
   // APB map (byte addresses); group block at group * 0x20
   // ----------------------------------------------------------------
   localparam logic [11:0] GRP_SPAN = 12'h080;
   localparam logic [4:0] REG_FUNC = 5'h00;
   localparam logic [4:0] REG_INVOD = 5'h04;
   localparam logic [4:0] REG_PULL = 5'h08;
   localparam logic [4:0] REG_DRV = 5'h0C;
   localparam logic [4:0] REG_GPO = 5'h10;
   localparam logic [4:0] REG_GPI = 5'h14;
   localparam logic [11:0] ADDR_CTRL = 12'h080;
   localparam logic [11:0] ADDR_STAT = 12'h084;
   localparam logic [11:0] STORE_BASE = 12'h400;
   localparam logic [11:0] STORE_END = 12'h6FC;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int F_P8 = 0;
   localparam int F_P9 = 2;
   localparam int F_P10 = 5;
   localparam int F_P5 = 7;
   localparam int F_P6 = 8;
   localparam int F_INV = 0;
   localparam int F_OD = 16;
   localparam int F_GOUT = 0;
   localparam int F_GDIR = 16;
   localparam int F_WAKE_EN = 0;
   localparam int F_WAKE_CH = 1;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [8:0] FUNC_RST = 9'h000;
   localparam logic [31:0] INVOD_RST = 32'h0000_0000;
   localparam logic [21:0] PULL_RST = 22'h15_5555;
   localparam logic [21:0] DRV_RST = 22'h15_5555;
   localparam logic [26:0] GPO_RST = 27'h000_0000;
   localparam logic [2:0] CTRL_RST = 3'h1;
   // ----------------------------------------------------------------
   // Function codes
   // ----------------------------------------------------------------
   localparam logic [1:0] P8_TXLAMP = 2'h0;
   localparam logic [1:0] P8_GPIO = 2'h1;
   localparam logic [1:0] P8_TXEN = 2'h2;
   localparam logic [1:0] P8_CLK = 2'h3;
   localparam logic [2:0] P9_RXLAMP = 3'h0;
   localparam logic [2:0] P9_GPIO = 3'h1;
   localparam logic [2:0] P9_TRXLAMP = 3'h2;
   localparam logic [2:0] P9_CLK = 3'h3;
   localparam logic [2:0] P9_SPECIAL = 3'h4;
   localparam logic [1:0] P10_DEFAULT = 2'h0;
   localparam logic [1:0] P10_ALT1 = 2'h1;
   localparam logic [1:0] P10_ALT2 = 2'h2;
   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic tx_active;
      logic rx_active;
      logic txd;
      logic rts;
      logic dtr;
      logic clk_out;
      logic pwm_a;
      logic pwm_b;
   } gmr_chan_t;
   typedef struct packed {
      logic rxd;
      logic cts;
      logic dsr;
      logic dcd;
      logic ri;
   } gmr_serin_t;
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RESP = 2'b10} gmr_state_t;
endpackage
`default_nettype wire

// ---- rtl/gmr_router.sv ----
// Contract
// - Eleven configurable pins in each of four groups, indexed zero to ten.
// - Pins 0-7 serial; pin 8 lamp/GPIO/driver enable/clock; pin 9 adds combined lamp, special.
// - Group-one pin 9 special is OR of suspend-low and charger-found flag.
// - Seven special functions, each mapped to at most one pin.
// - With bus-power sense selected, withhold USB attach until sense reads high.
// - Host-configured output: high on group-two pin 10, low on group-two pin 9.
// - Suspend output: low-active on group-three pin 10, high-active on pin 9.
// - Line-driver enable active while its channel transmits.
// - Transmit, receive and combined activity lamps follow channel traffic.
// - While suspended, a toggle of the single selected wakeup pin wakes the chip.
// - Charger-found output high when charging port detected, only on group-zero pin 9.
// - Each channel clock routable to its group pin 8 or pin 9.
// - Pulse-width units A and B drive group pins 6 and 5.
// - External config memory uses group-one pin 10 clock, group-two pin 10 data.
// - Every pin has polarity, open-drain, pull and drive-strength settings.
// - Multiplexer connects each function to its pin from stored settings.
// - On-chip store holds a 768-byte user area programmable over the bus.
// - Charger detection enabled only when its pin option is selected.
// - Pins without an output function come out of reset as inputs.
`timescale 1ns/1ps
`default_nettype none
module gmr_router
   import gmr_pkg::*;
(
   // Clock, enable, reset
   input wire logic I_CLK,
   input wire logic I_CE,
   input wire logic I_RST_B,
   // APB slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic O_PREADY,
   output logic [31:0] O_PRDATA,
   output logic O_PSLVERR,
   // Configuration loader
   input wire logic I_CFG_LOADED,
   // Channel functions
   input wire gmr_chan_t [3:0] I_CHAN,
   output gmr_serin_t [3:0] O_SERIN,
   // USB and power status
   input wire logic I_USB_CONFIGURED,
   input wire logic I_SUSPENDED,
   input wire logic I_CHARGER_FOUND,
   output logic O_ATTACH_EN,
   output logic O_WAKE_REQ,
   output logic O_CHG_DETECT_EN,
   // External configuration memory lines
   input wire logic I_EE_SCL_LOW,
   input wire logic I_EE_SDA_LOW,
   output logic O_EE_SCL_IN,
   output logic O_EE_SDA_IN,
   // Pins
   input wire logic [3:0][10:0] I_PIN,
   output logic [3:0][10:0] O_PIN,
   output logic [3:0][10:0] O_PIN_OE_B,
   output logic [3:0][10:0][1:0] O_PIN_PULL,
   output logic [3:0][10:0][1:0] O_PIN_DRV
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   gmr_state_t st_r, st_nxt;
   logic pready_r, pready_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic slverr_r, slverr_nxt;
   logic loaded_r, loaded_nxt;
   logic [3:0][8:0] func_r, func_nxt;
   logic [3:0][31:0] invod_r, invod_nxt;
   logic [3:0][10:0][1:0] pull_r, pull_nxt;
   logic [3:0][10:0][1:0] drv_r, drv_nxt;
   logic [3:0][26:0] gpo_r, gpo_nxt;
   logic [2:0] ctrl_r, ctrl_nxt;
   logic [31:0] store_r [STORE_WORDS];
   logic [3:0][10:0] pin_s1_r, pin_s2_r;
   logic [3:0][10:0] pin_r, pin_nxt;
   logic [3:0][10:0] oe_b_r, oe_b_nxt;
   gmr_serin_t [3:0] serin_r, serin_nxt;
   logic attach_r, attach_nxt;
   logic wake_r, wake_nxt;
   logic [3:0] wake_prev_r, wake_prev_nxt;
   logic chg_en_r, chg_en_nxt;
   logic ee_scl_r, ee_scl_nxt;
   logic ee_sda_r, ee_sda_nxt;
   logic [3:0][8:0] fx;
   logic [1:0] agrp;
   logic [4:0] aoff;
   logic in_grp, in_store, hit, wr_en;
   logic [7:0] sidx;
   logic [31:0] rd_val;
   logic wake_lvl, chg_ok;

   // ----------------------------------------------------------------
   // Pin synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
      begin
         pin_s1_r <= '1;
         pin_s2_r <= '1;
      end
      else if (I_CE)
      begin
         pin_s1_r <= I_PIN;
         pin_s2_r <= pin_s1_r;
      end
   end

   // ----------------------------------------------------------------
   // APB decode and register file
   // ----------------------------------------------------------------
   assign agrp = I_PADDR[6:5];
   assign aoff = I_PADDR[4:0];
   assign in_grp = (I_PADDR < GRP_SPAN) && (aoff <= REG_GPI) && (aoff[1:0] == 2'h0);
   assign in_store = (I_PADDR >= STORE_BASE) && (I_PADDR <= STORE_END) && (I_PADDR[1:0] == 2'h0);
   assign hit = in_grp || in_store || (I_PADDR == ADDR_CTRL) || (I_PADDR == ADDR_STAT);
   assign sidx = 8'((I_PADDR - STORE_BASE) >> 2);

   always_comb
   begin
      rd_val = 32'h0000_0000;
      if (in_store)
         rd_val = store_r[sidx];
      else if (I_PADDR == ADDR_CTRL)
         rd_val = {29'h0, ctrl_r};
      else if (I_PADDR == ADDR_STAT)
         rd_val = {26'h0, chg_ok, I_CHARGER_FOUND, I_SUSPENDED, I_USB_CONFIGURED, attach_r, loaded_r};
      else if (in_grp)
      begin
         case (aoff)
            REG_FUNC: rd_val = {23'h0, func_r[agrp]};
            REG_INVOD: rd_val = invod_r[agrp];
            REG_PULL: rd_val = {10'h0, pull_r[agrp]};
            REG_DRV: rd_val = {10'h0, drv_r[agrp]};
            REG_GPO: rd_val = {5'h0, gpo_r[agrp]};
            REG_GPI: rd_val = {21'h0, pin_s2_r[agrp]};
            default: rd_val = 32'h0000_0000;
         endcase
      end
   end

   // Two-cycle access: the answer is registered so every output is a flop
   always_comb
   begin
      st_nxt = st_r;
      pready_nxt = 1'b0;
      prdata_nxt = prdata_r;
      slverr_nxt = 1'b0;
      wr_en = 1'b0;
      case (st_r)
         ST_IDLE:
         begin
            if (I_PSEL && I_PENABLE)
            begin
               st_nxt = ST_RESP;
               pready_nxt = 1'b1;
               prdata_nxt = I_PWRITE ? 32'h0000_0000 : rd_val;
               slverr_nxt = !hit;
            end
         end
         ST_RESP:
         begin
            st_nxt = ST_IDLE;
            wr_en = I_PSEL && I_PENABLE && I_PWRITE && hit;
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   always_comb
   begin
      func_nxt = func_r;
      invod_nxt = invod_r;
      pull_nxt = pull_r;
      drv_nxt = drv_r;
      gpo_nxt = gpo_r;
      ctrl_nxt = ctrl_r;
      if (wr_en && in_grp)
      begin
         case (aoff)
            REG_FUNC: func_nxt[agrp] = I_PWDATA[8:0];
            REG_INVOD: invod_nxt[agrp] = I_PWDATA;
            REG_PULL: pull_nxt[agrp] = I_PWDATA[21:0];
            REG_DRV: drv_nxt[agrp] = I_PWDATA[21:0];
            REG_GPO: gpo_nxt[agrp] = I_PWDATA[26:0];
            default: gpo_nxt = gpo_r;
         endcase
      end
      if (wr_en && (I_PADDR == ADDR_CTRL))
         ctrl_nxt = I_PWDATA[2:0];
   end

   // Store is plain memory: not reset, written only on a completed access
   always_ff @(posedge I_CLK)
   begin
      if (I_CE && wr_en && in_store)
         store_r[sidx] <= I_PWDATA;
   end

   // ----------------------------------------------------------------
   // Effective selection
   // ----------------------------------------------------------------
   // Until the image is in, every pin keeps its factory role
   assign loaded_nxt = loaded_r || I_CFG_LOADED;
   always_comb
   begin
      for (int g = 0; g < NGRP; g++)
         fx[g] = loaded_r ? func_r[g] : FUNC_RST;
   end

   // Charger function exists only on group 0 pin 9, so one pin at most
   assign chg_en_nxt = (fx[0][F_P9 +: 3] == P9_SPECIAL);
   assign chg_ok = chg_en_r && I_CHARGER_FOUND;

   // ----------------------------------------------------------------
   // Pin multiplexer, one instance of the logic per group
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NGRP; g++)
   begin : grp
      logic [10:0] raw, en, val, inv, od;
      logic ee_line, ee_low;
      assign inv = invod_r[g][F_INV +: NPIN];
      assign od = invod_r[g][F_OD +: NPIN];
      always_comb
      begin
         raw = '0;
         en = '0;
         ee_line = 1'b0;
         ee_low = 1'b0;
         raw[0] = I_CHAN[g].txd;
         raw[2] = I_CHAN[g].rts;
         raw[4] = I_CHAN[g].dtr;
         en[0] = 1'b1;
         en[2] = 1'b1;
         en[4] = 1'b1;
         if (fx[g][F_P5])
         begin
            raw[5] = I_CHAN[g].pwm_b;
            en[5] = 1'b1;
         end
         if (fx[g][F_P6])
         begin
            raw[6] = I_CHAN[g].pwm_a;
            en[6] = 1'b1;
         end
         en[8] = 1'b1;
         case (fx[g][F_P8 +: 2])
            P8_TXLAMP: raw[8] = I_CHAN[g].tx_active;
            P8_TXEN: raw[8] = I_CHAN[g].tx_active;
            P8_CLK: raw[8] = I_CHAN[g].clk_out;
            default:
            begin
               raw[8] = gpo_r[g][F_GOUT + 8];
               en[8] = gpo_r[g][F_GDIR + 8];
            end
         endcase
         en[9] = 1'b1;
         case (fx[g][F_P9 +: 3])
            P9_RXLAMP: raw[9] = I_CHAN[g].rx_active;
            P9_TRXLAMP: raw[9] = I_CHAN[g].tx_active | I_CHAN[g].rx_active;
            P9_CLK: raw[9] = I_CHAN[g].clk_out;
            P9_SPECIAL:
            begin
               case (g)
                  0: raw[9] = chg_ok;
                  1: raw[9] = !I_SUSPENDED | chg_ok;
                  2: raw[9] = !I_USB_CONFIGURED;
                  default: raw[9] = I_SUSPENDED;
               endcase
            end
            default:
            begin
               raw[9] = gpo_r[g][F_GOUT + 9];
               en[9] = gpo_r[g][F_GDIR + 9];
            end
         endcase
         // Pin 10: group 0 is the reset input and is never driven
         case (g)
            1, 2:
            begin
               if (fx[g][F_P10 +: 2] == P10_DEFAULT)
               begin
                  raw[10] = gpo_r[g][F_GOUT + 10];
                  en[10] = gpo_r[g][F_GDIR + 10];
               end
               else if (fx[g][F_P10 +: 2] == P10_ALT2)
               begin
                  ee_line = 1'b1;
                  ee_low = (g == 1) ? I_EE_SCL_LOW : I_EE_SDA_LOW;
               end
               else if (g == 2)
               begin
                  raw[10] = I_USB_CONFIGURED;
                  en[10] = 1'b1;
               end
            end
            3:
            begin
               if (fx[g][F_P10 +: 2] == P10_DEFAULT)
               begin
                  raw[10] = !I_SUSPENDED;
                  en[10] = 1'b1;
               end
               else
               begin
                  raw[10] = gpo_r[g][F_GOUT + 10];
                  en[10] = gpo_r[g][F_GDIR + 10];
               end
            end
            default: en[10] = 1'b0;
         endcase
         // Gpio on 0-7 is not offered, so pins 1,3,7 always stay inputs
         val = raw ^ inv;
         pin_nxt[g] = val & ~od;
         oe_b_nxt[g] = ~(en & ~(od & val));
         // The memory bus is open-drain whatever the pin settings say
         if (ee_line)
         begin
            pin_nxt[g][10] = 1'b0;
            oe_b_nxt[g][10] = !ee_low;
         end
         serin_nxt[g].rxd = pin_s2_r[g][1] ^ inv[1];
         serin_nxt[g].cts = pin_s2_r[g][3] ^ inv[3];
         serin_nxt[g].dsr = pin_s2_r[g][5] ^ inv[5];
         serin_nxt[g].dcd = pin_s2_r[g][6] ^ inv[6];
         serin_nxt[g].ri = pin_s2_r[g][7] ^ inv[7];
      end
   end

   // ----------------------------------------------------------------
   // Attach, wakeup and memory line return
   // ----------------------------------------------------------------
   // Sense lives only on group 1 pin 10, a single candidate
   assign attach_nxt = (fx[1][F_P10 +: 2] == P10_ALT1) ? pin_s2_r[1][10] : 1'b1;
   // One channel select means only one ring input can hold the wake role
   assign wake_lvl = pin_s2_r[ctrl_r[F_WAKE_CH +: 2]][7];
   assign wake_prev_nxt = {pin_s2_r[3][7], pin_s2_r[2][7], pin_s2_r[1][7], pin_s2_r[0][7]};
   assign wake_nxt = ctrl_r[F_WAKE_EN] && I_SUSPENDED && (wake_lvl != wake_prev_r[ctrl_r[F_WAKE_CH +: 2]]);
   assign ee_scl_nxt = pin_s2_r[1][10];
   assign ee_sda_nxt = pin_s2_r[2][10];

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
      begin
         st_r <= ST_IDLE;
         pready_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         slverr_r <= 1'b0;
         loaded_r <= 1'b0;
         for (int g = 0; g < NGRP; g++)
         begin
            func_r[g] <= FUNC_RST;
            invod_r[g] <= INVOD_RST;
            pull_r[g] <= PULL_RST;
            drv_r[g] <= DRV_RST;
            gpo_r[g] <= GPO_RST;
         end
         ctrl_r <= CTRL_RST;
         pin_r <= '0;
         oe_b_r <= '1;
         serin_r <= '1;
         attach_r <= 1'b0;
         wake_r <= 1'b0;
         wake_prev_r <= '1;
         chg_en_r <= 1'b0;
         ee_scl_r <= 1'b1;
         ee_sda_r <= 1'b1;
      end
      else if (I_CE)
      begin
         st_r <= st_nxt;
         pready_r <= pready_nxt;
         prdata_r <= prdata_nxt;
         slverr_r <= slverr_nxt;
         loaded_r <= loaded_nxt;
         func_r <= func_nxt;
         invod_r <= invod_nxt;
         pull_r <= pull_nxt;
         drv_r <= drv_nxt;
         gpo_r <= gpo_nxt;
         ctrl_r <= ctrl_nxt;
         pin_r <= pin_nxt;
         oe_b_r <= oe_b_nxt;
         serin_r <= serin_nxt;
         attach_r <= attach_nxt;
         wake_r <= wake_nxt;
         wake_prev_r <= wake_prev_nxt;
         chg_en_r <= chg_en_nxt;
         ee_scl_r <= ee_scl_nxt;
         ee_sda_r <= ee_sda_nxt;
      end
   end

   assign O_PREADY = pready_r;
   assign O_PRDATA = prdata_r;
   assign O_PSLVERR = slverr_r;
   assign O_SERIN = serin_r;
   assign O_ATTACH_EN = attach_r;
   assign O_WAKE_REQ = wake_r;
   assign O_CHG_DETECT_EN = chg_en_r;
   assign O_EE_SCL_IN = ee_scl_r;
   assign O_EE_SDA_IN = ee_sda_r;
   assign O_PIN = pin_r;
   assign O_PIN_OE_B = oe_b_r;
   assign O_PIN_PULL = pull_r;
   assign O_PIN_DRV = drv_r;
endmodule
`default_nettype wire

// ---- sim/gmr_router_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module gmr_router_checker
   import gmr_pkg::*;
(
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_CE,
   input wire logic I_RST_B,
   // Register bus
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic O_PREADY,
   input wire logic [31:0] O_PRDATA,
   input wire logic O_PSLVERR,
   // Status and pins
   input wire logic I_CFG_LOADED,
   input wire logic I_SUSPENDED,
   input wire logic O_ATTACH_EN,
   input wire logic O_WAKE_REQ,
   input wire logic O_CHG_DETECT_EN,
   input wire logic [3:0][10:0] O_PIN_OE_B
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B);
   // ----------------------------------------------------------------
   // Load tracking
   // ----------------------------------------------------------------
   logic seen_r;
   logic seen_nxt;
   always_comb seen_nxt = I_RST_B & (seen_r | I_CFG_LOADED);
   always_ff @(posedge I_CLK)
   begin
      if (I_CE)
         seen_r <= seen_nxt;
   end
   sequence s_setup; I_CE && I_PSEL && !I_PENABLE; endsequence
   sequence s_access; s_setup ##1 (I_CE && I_PSEL && I_PENABLE); endsequence
   property p_answer; s_access |=> O_PREADY; endproperty
   a_answer: assert property (p_answer) else $error("no ready after access");
   property p_pulse; I_CE && O_PREADY |=> !O_PREADY; endproperty
   a_pulse: assert property (p_pulse) else $error("ready held too long");
   property p_err; O_PSLVERR |-> O_PREADY; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_wr0; (s_access ##0 I_PWRITE) |=> O_PRDATA == 32'h0; endproperty
   a_wr0: assert property (p_wr0) else $error("read data on a write");
   property p_wake_pulse; I_CE && O_WAKE_REQ |=> !O_WAKE_REQ; endproperty
   a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than a pulse");
   property p_wake_susp; O_WAKE_REQ |-> $past(I_SUSPENDED); endproperty
   a_wake_susp: assert property (p_wake_susp) else $error("wake while awake");
   property p_nodrive; O_PIN_OE_B[0][10]; endproperty
   a_nodrive: assert property (p_nodrive) else $error("reset pad driven");
   property p_attach; !seen_r && $past(I_RST_B) |-> O_ATTACH_EN; endproperty
   a_attach: assert property (p_attach) else $error("attach held before load");
   property p_chg; O_CHG_DETECT_EN |-> seen_r; endproperty
   a_chg: assert property (p_chg) else $error("charger detect before load");
endmodule
bind gmr_router gmr_router_checker u_gmr_router_checker (.I_CLK, .I_CE, .I_RST_B, .I_PSEL, .I_PENABLE,
   .I_PWRITE, .O_PREADY, .O_PRDATA, .O_PSLVERR, .I_CFG_LOADED, .I_SUSPENDED, .O_ATTACH_EN, .O_WAKE_REQ,
   .O_CHG_DETECT_EN, .O_PIN_OE_B);
`default_nettype wire

// ---- sim/gmr_pads.sv ----
`timescale 1ns/1ps
`default_nettype none
module gmr_pads
   import gmr_pkg::*;
(
   // Device side
   input wire logic i_clk,
   input wire logic [3:0][10:0] i_pin,
   input wire logic [3:0][10:0] i_oe_b,
   input wire logic [3:0][10:0][1:0] i_pull,
   // Outside parties
   input wire logic [3:0][10:0] i_ext_en,
   input wire logic [3:0][10:0] i_ext_val,
   output logic [3:0][10:0] o_pad
);
   // Floating pads wander so a stale level never reads as valid
   logic tog_r = 1'b0;
   always_ff @(posedge i_clk) tog_r <= !tog_r;
   always_comb
   begin
      for (int g = 0; g < NGRP; g++)
      begin
         for (int p = 0; p < NPIN; p++)
         begin
            if (!i_oe_b[g][p])
               o_pad[g][p] = i_pin[g][p];
            else if (i_ext_en[g][p])
               o_pad[g][p] = i_ext_val[g][p];
            else if (i_pull[g][p] == 2'b01)
               o_pad[g][p] = 1'b1;
            else if (i_pull[g][p] == 2'b10)
               o_pad[g][p] = 1'b0;
            else
               o_pad[g][p] = tog_r ^ p[0];
         end
      end
   end
endmodule
`default_nettype wire

// ---- sim/gmr_router_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module gmr_router_tb
   import gmr_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic loaded_in = 1'b0;
   logic usb_cfg = 1'b0;
   logic susp = 1'b0;
   logic chg = 1'b0;
   gmr_chan_t [3:0] chan = '0;
   gmr_serin_t [3:0] serin;
   logic ee_low = 1'b0;
   logic ee_scl;
   // Ring inputs and pin 10 are driven from outside, the rest float on pulls
   logic [3:0][10:0] ext_en = {4{11'h480}};
   logic [3:0][10:0] ext_val = '0;
   logic [3:0][10:0] pad;
   logic pready;
   logic [31:0] prdata;
   logic pslverr;
   logic attach;
   logic wake;
   logic chg_en;
   logic [3:0][10:0] opin;
   logic [3:0][10:0] oe_b;
   logic [3:0][10:0][1:0] pull;
   logic [3:0][10:0][1:0] drv;
   int fail_count = 0;
   int n_compared = 0;
   int func_m [4] = '{0, 0, 0, 0};
   bit loaded_m = 1'b0;
   logic [31:0] q;
   logic e;
   int n;
   logic [31:0] store_q [$];
   always #20 clk = ~clk;
   gmr_router u_gmr_router (.I_CLK(clk), .I_CE(1'b1), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready), .O_PRDATA(prdata),
      .O_PSLVERR(pslverr), .I_CFG_LOADED(loaded_in), .I_CHAN(chan), .O_SERIN(serin), .I_USB_CONFIGURED(usb_cfg),
      .I_SUSPENDED(susp), .I_CHARGER_FOUND(chg), .O_ATTACH_EN(attach), .O_WAKE_REQ(wake),
      .O_CHG_DETECT_EN(chg_en), .I_EE_SCL_LOW(ee_low), .I_EE_SDA_LOW(1'b0), .O_EE_SCL_IN(ee_scl), .O_EE_SDA_IN(),
      .I_PIN(pad), .O_PIN(opin), .O_PIN_OE_B(oe_b), .O_PIN_PULL(pull), .O_PIN_DRV(drv));
   gmr_pads u_gmr_pads (.i_clk(clk), .i_pin(opin), .i_oe_b(oe_b), .i_pull(pull), .i_ext_en(ext_en),
      .i_ext_val(ext_val), .o_pad(pad));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task tally_and_finish;
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] x, input logic [31:0] got);
      n_compared++;
      if (got !== x)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, got);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rq, output logic re);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 16)
      begin
         fail_count++;
         tally_and_finish;
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, q, e);
      chk("wr_err", 32'h0, e);
   endtask
   task rd(input string nm, input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, q, e);
      chk(nm, x, q);
   endtask
   task cnt_wake(output int c);
      c = 0;
      repeat (8)
      begin
         @(posedge clk);
         if (wake === 1'b1)
            c++;
      end
   endtask
   // Codes 0 and 2 both follow transmit activity
   function automatic logic p8(input int g);
      p8 = (loaded_m && func_m[g] % 4 == 3) ? chan[g].clk_out : chan[g].tx_active;
   endfunction
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      void'($urandom(32'h48F2));
      repeat (4) @(posedge clk);
      chk("oe_b_all", 32'h1, &oe_b);
      chk("pull_all", 32'h1, pull === {44{2'b01}});
      chk("drv_all", 32'h1, drv === {44{2'b01}});
      chk("attach_rst", 32'h0, attach);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      chk("attach_dflt", 32'h1, attach);
      chk("g1p10_oe", 32'h1, oe_b[1][10]);
      chk("g3p10", !susp, opin[3][10]);
      $display("test reset done");
      rd("func_rst", 12'h020, 32'h0);
      rd("ctrl_rst", ADDR_CTRL, 32'(CTRL_RST));
      apb(1'b0, 12'h018, 32'h0, q, e);
      chk("unmapped_err", 32'h1, e);
      chk("unmapped_rd", 32'h0, q);
      for (int k = 0; k < 2; k++)
      begin
         store_q.push_back($urandom);
         wr(k ? STORE_END : STORE_BASE, store_q[k]);
      end
      for (int k = 0; k < 2; k++)
         rd("store", k ? STORE_END : STORE_BASE, store_q.pop_front());
      $display("test registers done");
      func_m = '{32'h012, 32'h030, 32'h02C, 32'h103};
      for (int g = 0; g < NGRP; g++)
         wr(12'(g * 32), func_m[g]);
      rd("func_g3", 12'h060, 32'h103);
      chan <= $urandom;
      repeat (3) @(posedge clk);
      for (int g = 0; g < NGRP; g++)
         chk("pin8_pre", p8(g), opin[g][8]);
      chk("g0p9_pre", chan[0].rx_active, opin[0][9]);
      chk("chg_en_pre", 32'h0, chg_en);
      $display("test preload done");
      loaded_in <= 1'b1;
      @(posedge clk);
      loaded_in <= 1'b0;
      loaded_m = 1'b1;
      repeat (3) @(posedge clk);
      chk("chg_en", 32'h1, chg_en);
      repeat (8)
      begin
         chan <= $urandom;
         {usb_cfg, susp, chg} <= 3'($urandom);
         ext_val <= 44'({$urandom, $urandom});
         repeat (4) @(posedge clk);
         for (int g = 0; g < NGRP; g++)
            chk("pin8", p8(g), opin[g][8]);
         chk("g0p9", chg, opin[0][9]);
         chk("g1p9", !susp | chg, opin[1][9]);
         chk("g2p9", chan[2].clk_out, opin[2][9]);
         chk("g2p10", usb_cfg, opin[2][10]);
         chk("g3p6", chan[3].pwm_a, opin[3][6]);
         chk("g3p10", !susp, opin[3][10]);
         chk("attach", ext_val[1][10], attach);
      end
      $display("test routing done");
      susp <= 1'b1;
      wr(ADDR_CTRL, 32'h5);
      ext_val[1][7] <= !ext_val[1][7];
      cnt_wake(n);
      chk("wake_other", 32'h0, n);
      ext_val[2][7] <= !ext_val[2][7];
      cnt_wake(n);
      chk("wake_sel", 32'h1, n);
      $display("test wake done");
      ee_low <= 1'b1;
      wr(12'h020, 32'h050);
      repeat (5) @(posedge clk);
      chk("ee_scl_oe", 32'h0, oe_b[1][10]);
      chk("ee_scl_in", 32'h0, ee_scl);
      chk("ri3_in", ext_val[3][7], serin[3].ri);
      ee_low <= 1'b0;
      repeat (5) @(posedge clk);
      chk("ee_scl_rel", ext_val[1][10], ee_scl);
      $display("test memory lines done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
